// *** include/fp_eval_if.sv ***
// Operand and result bundle between the control core and its two evaluators.
`timescale 1ns/10ps
interface fp_eval_if;
	logic [79:0] tos;
	logic [79:0] src;
	logic tos_empty;
	logic lt;
	logic eq;
	logic gt;
	logic unord;
	logic loud;
	logic [2:0] tos_class;
	logic tos_sign;
	modport core (output tos, src, tos_empty, input lt, eq, gt, unord, loud, tos_class, tos_sign);
	modport order (input tos, src, tos_empty, output lt, eq, gt, unord, loud);
	modport classify (input tos, tos_empty, output tos_class, tos_sign);
endinterface

// *** include/fpcc_pkg.sv ***
// Shared constants, encodings and the operand classifier for the compare unit.
package fpcc_pkg;
	localparam logic [7:0] OFF_TOS_LO = 8'h00;
	localparam logic [7:0] OFF_TOS_MID = 8'h04;
	localparam logic [7:0] OFF_TOS_HI = 8'h08;
	localparam logic [7:0] OFF_SRC_LO = 8'h0C;
	localparam logic [7:0] OFF_SRC_MID = 8'h10;
	localparam logic [7:0] OFF_SRC_HI = 8'h14;
	localparam logic [7:0] OFF_INT_SRC = 8'h18;
	localparam logic [7:0] OFF_COMMAND = 8'h1C;
	localparam logic [7:0] OFF_STATUS_WORD = 8'h20;
	localparam logic [7:0] OFF_INT_FLAGS = 8'h24;
	localparam logic [7:0] OFF_ACCUM = 8'h28;
	localparam logic [7:0] OFF_FEATURE = 8'h2C;
	localparam logic [7:0] OFF_POP_COUNT = 8'h30;

	localparam int SW_IE = 0;
	localparam int SW_CC0 = 8;
	localparam int SW_CC1 = 9;
	localparam int SW_CC2 = 10;
	localparam int SW_TOP_LSB = 11;
	localparam int SW_TOP_MSB = 13;
	localparam int SW_CC3 = 14;
	localparam int IF_CF = 0;
	localparam int IF_PF = 2;
	localparam int IF_ZF = 6;
	localparam int HI_EMPTY = 16;
	localparam int FEAT_FLAG_CMP = 0;

	localparam logic [15:0] STATUS_RST = 16'h0000;
	localparam logic [2:0] IFLAGS_RST = 3'h0;
	localparam logic TOS_EMPTY_RST = 1'b1;

	localparam logic [14:0] EXP_MAX = 15'h7FFF;
	localparam logic [14:0] EXP_BIAS = 15'h3FFF;
	localparam logic [14:0] INT_MSB = 15'h001F;

	localparam logic [2:0] CLS_UNSUPP = 3'h0;
	localparam logic [2:0] CLS_NAN = 3'h1;
	localparam logic [2:0] CLS_NORMAL = 3'h2;
	localparam logic [2:0] CLS_INF = 3'h3;
	localparam logic [2:0] CLS_ZERO = 3'h4;
	localparam logic [2:0] CLS_EMPTY = 3'h5;
	localparam logic [2:0] CLS_DENORM = 3'h6;

	localparam logic [2:0] REL_GT = 3'h0;
	localparam logic [2:0] REL_LT = 3'h1;
	localparam logic [2:0] REL_EQ = 3'h4;
	localparam logic [2:0] REL_UN = 3'h7;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		OP_NONE, OP_FP_COMPARE, OP_FP_COMPARE_POP, OP_FP_COMPARE_POP2,
		OP_QUIET_COMPARE, OP_QUIET_COMPARE_POP, OP_QUIET_COMPARE_POP2,
		OP_INT_SOURCE_COMPARE, OP_INT_SOURCE_COMPARE_POP, OP_COMPARE_WITH_ZERO,
		OP_FLAG_SETTING_COMPARE, OP_FLAG_SETTING_COMPARE_POP,
		OP_QUIET_FLAG_COMPARE, OP_QUIET_FLAG_COMPARE_POP,
		OP_EXAMINE_CLASS, OP_STORE_FP_STATUS_WORD
	} op_t;

	// Pseudo-denormals fall in the denormal class, unnormals count as unsupported.
	function automatic logic [2:0] classify80(input logic [79:0] v);
		if (v[78:64] == EXP_MAX) begin
			return v[63] ? ((v[62:0] == '0) ? CLS_INF : CLS_NAN) : CLS_UNSUPP;
		end
		if (v[78:64] == '0) begin
			return (v[63:0] == '0) ? CLS_ZERO : CLS_DENORM;
		end
		return v[63] ? CLS_NORMAL : CLS_UNSUPP;
	endfunction
endpackage

// *** src/fp_classify.sv ***
// Classifies the top-of-stack value and reports its sign.
`timescale 1ns/10ps
module fp_classify (
	fp_eval_if.classify ev
);
	assign ev.tos_class = ev.tos_empty ? fpcc_pkg::CLS_EMPTY : fpcc_pkg::classify80(ev.tos);
	assign ev.tos_sign = ev.tos[79];
endmodule

// *** src/fp_compare_classify_flags.sv ***
// Compare, classify and flag unit with its AXI4-Lite register slave.
// Notes on behaviour
// - Compare into cc3/cc2/cc0: less gives 001, equal 100, unordered 111.
// - Integer source is widened to extended precision, then compared like a float.
// - Popping integer-source compare pops the stack once after comparing.
// - Compare with zero is the plain compare against a source of 0.0.
// - Flag-setting compares report through zero, parity and carry flags.
// - Flag codes: greater 000, less 001, equal 100, unordered 111.
// - Quiet flag compares raise no invalid when only quiet NaNs cause unordered.
// - Popping flag compares, ordinary and quiet, pop the stack once afterwards.
// - Feature identification reports whether flag-setting compares exist.
// - Examine classifies top of stack and encodes the class in the cc flags.
// - Examine also puts the sign of top of stack into cc1.
// - The status word can be copied into the integer accumulator.
// - Status word positions: cc2 at 0400H, cc0 at 0100H, cc3 at 4000H.
// - Compare with top of stack greater clears cc3, cc2 and cc0.
// - Unordered when either operand is a NaN or unsupported.
// - Ordinary compares raise invalid on unordered; quiet ones not for quiet NaNs.
// - Popping condition-code compares pop once or twice after comparing.
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module fp_compare_classify_flags #(
	parameter bit FLAG_CMP_SUPPORTED = 1'b1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	if ($bits(fpcc_pkg::op_t) != 4) begin : g_bad
		$error("Command field must be four bits wide.");
	end

	function automatic logic is_cc_cmp(input fpcc_pkg::op_t op);
		return op >= fpcc_pkg::OP_FP_COMPARE && op <= fpcc_pkg::OP_COMPARE_WITH_ZERO;
	endfunction

	function automatic logic is_flag_cmp(input fpcc_pkg::op_t op);
		return op >= fpcc_pkg::OP_FLAG_SETTING_COMPARE && op <= fpcc_pkg::OP_QUIET_FLAG_COMPARE_POP;
	endfunction

	function automatic logic is_quiet(input fpcc_pkg::op_t op);
		return op == fpcc_pkg::OP_QUIET_COMPARE || op == fpcc_pkg::OP_QUIET_COMPARE_POP
			|| op == fpcc_pkg::OP_QUIET_COMPARE_POP2 || op == fpcc_pkg::OP_QUIET_FLAG_COMPARE
			|| op == fpcc_pkg::OP_QUIET_FLAG_COMPARE_POP;
	endfunction

	function automatic logic [1:0] pops(input fpcc_pkg::op_t op);
		unique case (op)
			fpcc_pkg::OP_FP_COMPARE_POP, fpcc_pkg::OP_QUIET_COMPARE_POP,
			fpcc_pkg::OP_INT_SOURCE_COMPARE_POP, fpcc_pkg::OP_FLAG_SETTING_COMPARE_POP,
			fpcc_pkg::OP_QUIET_FLAG_COMPARE_POP: return 2'h1;
			fpcc_pkg::OP_FP_COMPARE_POP2, fpcc_pkg::OP_QUIET_COMPARE_POP2: return 2'h2;
			default: return 2'h0;
		endcase
	endfunction

	function automatic logic [79:0] int_to_ext(input logic [31:0] v);
		logic [31:0] mag;
		logic [5:0] lz;
		mag = v[31] ? (~v + 32'h0000_0001) : v;
		lz = 6'h00;
		for (int i = 0; i < 31; i++) begin
			if (!mag[31]) begin
				mag = mag << 1;
				lz = lz + 6'h01;
			end
		end
		if (mag == '0) begin
			return '0;
		end
		return {v[31], fpcc_pkg::EXP_BIAS + fpcc_pkg::INT_MSB - {9'h000, lz}, mag, 32'h0000_0000};
	endfunction

	fp_eval_if ev ();

	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic aw_full_q;
	logic w_full_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_go;
	logic wr_ok;
	logic [31:0] rd_data;
	logic rd_ok;
	logic [31:0] tos_lo_q;
	logic [31:0] tos_mid_q;
	logic [15:0] tos_hi_q;
	logic tos_empty_q;
	logic [31:0] src_lo_q;
	logic [31:0] src_mid_q;
	logic [15:0] src_hi_q;
	logic [31:0] int_src_q;
	fpcc_pkg::op_t op_q;
	fpcc_pkg::op_t wr_op;
	logic exec_q;
	logic [15:0] status_q;
	logic [2:0] iflags_q;
	logic [15:0] accum_q;
	logic [15:0] pop_count_q;
	logic [2:0] rel;
	logic raise_invalid;

	fp_order u_order (
		.ev(ev.order)
	);

	fp_classify u_classify (
		.ev(ev.classify)
	);

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// Address and data are held separately so the master may present them in either order.
	assign wr_go = aw_full_q && w_full_q && !bvalid_q;
	assign wr_op = fpcc_pkg::op_t'(wdata_q[3:0]);

	always_comb begin
		wr_ok = 1'b1;
		unique case (awaddr_q)
			fpcc_pkg::OFF_TOS_LO, fpcc_pkg::OFF_TOS_MID, fpcc_pkg::OFF_TOS_HI,
			fpcc_pkg::OFF_SRC_LO, fpcc_pkg::OFF_SRC_MID, fpcc_pkg::OFF_SRC_HI,
			fpcc_pkg::OFF_INT_SRC, fpcc_pkg::OFF_STATUS_WORD, fpcc_pkg::OFF_INT_FLAGS: wr_ok = 1'b1;
			// Flag-setting commands are refused when the unit is built without them.
			fpcc_pkg::OFF_COMMAND: wr_ok = FLAG_CMP_SUPPORTED || !is_flag_cmp(wr_op);
			default: wr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			awready_q <= 1'b1;
			aw_full_q <= 1'b0;
			awaddr_q <= 8'h00;
		end else if (awvalid && awready_q) begin
			awready_q <= 1'b0;
			aw_full_q <= 1'b1;
			awaddr_q <= {awaddr[7:2], 2'h0};
		end else if (wr_go) begin
			awready_q <= 1'b1;
			aw_full_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wready_q <= 1'b1;
			w_full_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else if (wvalid && wready_q) begin
			wready_q <= 1'b0;
			w_full_q <= 1'b1;
			wdata_q <= wdata;
			wstrb_q <= wstrb;
		end else if (wr_go) begin
			wready_q <= 1'b1;
			w_full_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bvalid_q <= 1'b0;
			bresp_q <= fpcc_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_ok ? fpcc_pkg::RESP_OKAY : fpcc_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end

	always_comb begin
		rd_data = '0;
		rd_ok = 1'b1;
		unique case ({araddr[7:2], 2'h0})
			fpcc_pkg::OFF_TOS_LO: rd_data = tos_lo_q;
			fpcc_pkg::OFF_TOS_MID: rd_data = tos_mid_q;
			fpcc_pkg::OFF_TOS_HI: rd_data = {15'h0000, tos_empty_q, tos_hi_q};
			fpcc_pkg::OFF_SRC_LO: rd_data = src_lo_q;
			fpcc_pkg::OFF_SRC_MID: rd_data = src_mid_q;
			fpcc_pkg::OFF_SRC_HI: rd_data = {16'h0000, src_hi_q};
			fpcc_pkg::OFF_INT_SRC: rd_data = int_src_q;
			fpcc_pkg::OFF_COMMAND: rd_data = {28'h000_0000, op_q};
			fpcc_pkg::OFF_STATUS_WORD: rd_data = {16'h0000, status_q};
			fpcc_pkg::OFF_INT_FLAGS: begin
				rd_data[fpcc_pkg::IF_ZF] = iflags_q[2];
				rd_data[fpcc_pkg::IF_PF] = iflags_q[1];
				rd_data[fpcc_pkg::IF_CF] = iflags_q[0];
			end
			fpcc_pkg::OFF_ACCUM: rd_data = {16'h0000, accum_q};
			fpcc_pkg::OFF_FEATURE: rd_data[fpcc_pkg::FEAT_FLAG_CMP] = FLAG_CMP_SUPPORTED;
			fpcc_pkg::OFF_POP_COUNT: rd_data = {16'h0000, pop_count_q};
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= fpcc_pkg::RESP_OKAY;
		end else if (arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_data;
			rresp_q <= rd_ok ? fpcc_pkg::RESP_OKAY : fpcc_pkg::RESP_SLVERR;
		end else if (rvalid_q && rready) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tos_lo_q <= 32'h0000_0000;
			tos_mid_q <= 32'h0000_0000;
			tos_hi_q <= 16'h0000;
			tos_empty_q <= fpcc_pkg::TOS_EMPTY_RST;
		end else if (wr_go && awaddr_q == fpcc_pkg::OFF_TOS_LO) begin
			tos_lo_q <= merge(tos_lo_q, wdata_q, wstrb_q);
		end else if (wr_go && awaddr_q == fpcc_pkg::OFF_TOS_MID) begin
			tos_mid_q <= merge(tos_mid_q, wdata_q, wstrb_q);
		end else if (wr_go && awaddr_q == fpcc_pkg::OFF_TOS_HI) begin
			tos_hi_q <= 16'(merge({16'h0000, tos_hi_q}, wdata_q, wstrb_q));
			if (wstrb_q[2]) begin
				tos_empty_q <= wdata_q[fpcc_pkg::HI_EMPTY];
			end
		end else if (exec_q && pops(op_q) != 2'h0) begin
			// A pop leaves no value behind in the modelled top register.
			tos_empty_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			src_lo_q <= 32'h0000_0000;
			src_mid_q <= 32'h0000_0000;
			src_hi_q <= 16'h0000;
			int_src_q <= 32'h0000_0000;
		end else if (wr_go) begin
			if (awaddr_q == fpcc_pkg::OFF_SRC_LO) begin
				src_lo_q <= merge(src_lo_q, wdata_q, wstrb_q);
			end
			if (awaddr_q == fpcc_pkg::OFF_SRC_MID) begin
				src_mid_q <= merge(src_mid_q, wdata_q, wstrb_q);
			end
			if (awaddr_q == fpcc_pkg::OFF_SRC_HI) begin
				src_hi_q <= 16'(merge({16'h0000, src_hi_q}, wdata_q, wstrb_q));
			end
			if (awaddr_q == fpcc_pkg::OFF_INT_SRC) begin
				int_src_q <= merge(int_src_q, wdata_q, wstrb_q);
			end
		end
	end

	// A command write starts one evaluation in the following cycle.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			op_q <= fpcc_pkg::OP_NONE;
			exec_q <= 1'b0;
		end else begin
			exec_q <= wr_go && wr_ok && awaddr_q == fpcc_pkg::OFF_COMMAND && wstrb_q[0];
			if (wr_go && wr_ok && awaddr_q == fpcc_pkg::OFF_COMMAND && wstrb_q[0]) begin
				op_q <= wr_op;
			end
		end
	end

	assign ev.tos = {tos_hi_q, tos_mid_q, tos_lo_q};
	assign ev.tos_empty = tos_empty_q;

	always_comb begin
		if (op_q == fpcc_pkg::OP_COMPARE_WITH_ZERO) begin
			ev.src = '0;
		end else if (op_q == fpcc_pkg::OP_INT_SOURCE_COMPARE || op_q == fpcc_pkg::OP_INT_SOURCE_COMPARE_POP) begin
			ev.src = int_to_ext(int_src_q);
		end else begin
			ev.src = {src_hi_q, src_mid_q, src_lo_q};
		end
	end

	// The same code serves both the cc triple and the zero/parity/carry triple.
	assign rel = ev.unord ? fpcc_pkg::REL_UN : ev.eq ? fpcc_pkg::REL_EQ
		: ev.lt ? fpcc_pkg::REL_LT : fpcc_pkg::REL_GT;
	assign raise_invalid = (is_cc_cmp(op_q) || is_flag_cmp(op_q))
		&& (is_quiet(op_q) ? ev.loud : ev.unord);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			status_q <= fpcc_pkg::STATUS_RST;
		end else begin
			if (wr_go && awaddr_q == fpcc_pkg::OFF_STATUS_WORD && wstrb_q[0] && wdata_q[fpcc_pkg::SW_IE]) begin
				status_q[fpcc_pkg::SW_IE] <= 1'b0;
			end
			if (exec_q) begin
				if (is_cc_cmp(op_q)) begin
					// Compare results land at mask 4000H, 0400H and 0100H of the word.
					{status_q[fpcc_pkg::SW_CC3], status_q[fpcc_pkg::SW_CC2], status_q[fpcc_pkg::SW_CC0]} <= rel;
					status_q[fpcc_pkg::SW_CC1] <= 1'b0;
				end
				if (op_q == fpcc_pkg::OP_EXAMINE_CLASS) begin
					{status_q[fpcc_pkg::SW_CC3], status_q[fpcc_pkg::SW_CC2], status_q[fpcc_pkg::SW_CC0]} <= ev.tos_class;
					status_q[fpcc_pkg::SW_CC1] <= ev.tos_sign;
				end
				if (raise_invalid) begin
					status_q[fpcc_pkg::SW_IE] <= 1'b1;
				end
				status_q[fpcc_pkg::SW_TOP_MSB:fpcc_pkg::SW_TOP_LSB] <=
					status_q[fpcc_pkg::SW_TOP_MSB:fpcc_pkg::SW_TOP_LSB] + {1'b0, pops(op_q)};
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			iflags_q <= fpcc_pkg::IFLAGS_RST;
		end else if (exec_q && is_flag_cmp(op_q)) begin
			iflags_q <= rel;
		end else if (wr_go && awaddr_q == fpcc_pkg::OFF_INT_FLAGS && wstrb_q[0]) begin
			iflags_q <= {wdata_q[fpcc_pkg::IF_ZF], wdata_q[fpcc_pkg::IF_PF], wdata_q[fpcc_pkg::IF_CF]};
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			accum_q <= 16'h0000;
			pop_count_q <= 16'h0000;
		end else if (exec_q) begin
			if (op_q == fpcc_pkg::OP_STORE_FP_STATUS_WORD) begin
				accum_q <= status_q;
			end
			pop_count_q <= pop_count_q + {14'h0000, pops(op_q)};
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_cc_less_code: assert property (exec_q && is_cc_cmp(op_q) && ev.lt |=>
		{status_q[fpcc_pkg::SW_CC3], status_q[fpcc_pkg::SW_CC2], status_q[fpcc_pkg::SW_CC0]} == 3'h1)
		else $error("Less-than compare did not give cc 001.");
	a_cc_greater_clear: assert property (exec_q && is_cc_cmp(op_q) && ev.gt |=>
		!status_q[fpcc_pkg::SW_CC3] && !status_q[fpcc_pkg::SW_CC2] && !status_q[fpcc_pkg::SW_CC0])
		else $error("Greater compare left a cc flag set.");
	a_flag_equal_code: assert property (exec_q && is_flag_cmp(op_q) && ev.eq |=> iflags_q == 3'h4)
		else $error("Equal flag compare did not give 100.");
	a_flag_keeps_cc: assert property (exec_q && is_flag_cmp(op_q) |=>
		{status_q[fpcc_pkg::SW_CC3], status_q[fpcc_pkg::SW_CC2:fpcc_pkg::SW_CC0]}
		== $past({status_q[fpcc_pkg::SW_CC3], status_q[fpcc_pkg::SW_CC2:fpcc_pkg::SW_CC0]}))
		else $error("Flag compare changed the cc flags.");
	a_cc_keeps_flags: assert property (exec_q && is_cc_cmp(op_q) |=> $stable(iflags_q))
		else $error("Condition-code compare changed the integer flags.");
	a_zero_source: assert property (exec_q && op_q == fpcc_pkg::OP_COMPARE_WITH_ZERO |-> ev.src == '0)
		else $error("Zero compare used a nonzero source.");
	a_int_widen: assert property (exec_q && op_q == fpcc_pkg::OP_INT_SOURCE_COMPARE |->
		ev.src[79] == int_src_q[31] && (int_src_q == '0 || ev.src[63]))
		else $error("Integer source not widened to a normal value.");
	a_pop_count: assert property (exec_q && pops(op_q) != 2'h0 |=>
		pop_count_q == $past(pop_count_q) + {14'h0000, $past(pops(op_q))} && tos_empty_q)
		else $error("Pop count or empty mark not updated after a popping compare.");
	a_quiet_silent: assert property (exec_q && is_quiet(op_q) && ev.unord && !ev.loud |=>
		status_q[fpcc_pkg::SW_IE] == $past(status_q[fpcc_pkg::SW_IE]))
		else $error("Quiet compare raised invalid for a quiet NaN.");
	a_unord_invalid: assert property (exec_q && is_cc_cmp(op_q) && !is_quiet(op_q) && ev.unord |=>
		status_q[fpcc_pkg::SW_IE] && status_q[fpcc_pkg::SW_CC2])
		else $error("Unordered compare did not raise invalid.");
	a_examine_sign: assert property (exec_q && op_q == fpcc_pkg::OP_EXAMINE_CLASS |=>
		status_q[fpcc_pkg::SW_CC1] == $past(tos_hi_q[15]))
		else $error("Examine did not report the sign in cc1.");
	a_store_status: assert property (exec_q && op_q == fpcc_pkg::OP_STORE_FP_STATUS_WORD |=>
		accum_q == $past(status_q))
		else $error("Accumulator does not hold the stored status word.");
	a_zero_equal: assert property (!ev.unord && ev.tos[78:0] == '0 && ev.src[78:0] == '0 |-> ev.eq)
		else $error("Zeros of opposite sign not equal.");
endmodule

// *** src/fp_order.sv ***
// Orders top of stack against the source operand.
`timescale 1ns/10ps
module fp_order (
	fp_eval_if.order ev
);
	logic [2:0] a_cls;
	logic [2:0] b_cls;
	logic a_bad;
	logic b_bad;
	logic a_quiet;
	logic b_quiet;
	logic mag_lt;

	assign a_cls = fpcc_pkg::classify80(ev.tos);
	assign b_cls = fpcc_pkg::classify80(ev.src);
	// An empty top register is a stack fault and is treated like an unsupported operand.
	assign a_bad = ev.tos_empty || a_cls == fpcc_pkg::CLS_NAN || a_cls == fpcc_pkg::CLS_UNSUPP;
	assign b_bad = b_cls == fpcc_pkg::CLS_NAN || b_cls == fpcc_pkg::CLS_UNSUPP;
	assign a_quiet = !ev.tos_empty && a_cls == fpcc_pkg::CLS_NAN && ev.tos[62];
	assign b_quiet = b_cls == fpcc_pkg::CLS_NAN && ev.src[62];
	assign ev.unord = a_bad || b_bad;
	assign ev.loud = (a_bad && !a_quiet) || (b_bad && !b_quiet);
	assign mag_lt = ev.tos[78:0] < ev.src[78:0];
	// Zeros of either sign are equal; otherwise sign first, then magnitude.
	assign ev.eq = !ev.unord && ((a_cls == fpcc_pkg::CLS_ZERO && b_cls == fpcc_pkg::CLS_ZERO)
		|| ev.tos == ev.src);
	assign ev.lt = !ev.unord && !ev.eq && ((ev.tos[79] != ev.src[79]) ? ev.tos[79]
		: (ev.tos[79] ? !mag_lt : mag_lt));
	assign ev.gt = !ev.unord && !ev.eq && !ev.lt;
endmodule

// *** verif/axi_lite_master.sv ***
// Register bus master model standing in for the instruction issue side.
`timescale 1ns/10ps
module axi_lite_master (
	input wire logic clk,
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	output logic bready,
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	output logic rready
);
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
	end
	// Each valid is held until its own ready and each ready until its valid; the edge wait keeps two calls apart.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic pa, pw, pb;
		@(posedge clk);
		{pa, pw, pb} = 3'b111;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		{awvalid, wvalid, bready} <= 3'b111;
		while (pa || pw || pb) begin
			@(posedge clk);
			if (pa && awready) begin
				pa = 1'b0;
				awvalid <= 1'b0;
			end
			if (pw && wready) begin
				pw = 1'b0;
				wvalid <= 1'b0;
			end
			if (pb && bvalid) begin
				pb = 1'b0;
				bready <= 1'b0;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a);
		logic pa, pr;
		@(posedge clk);
		{pa, pr} = 2'b11;
		araddr <= a;
		{arvalid, rready} <= 2'b11;
		while (pa || pr) begin
			@(posedge clk);
			if (pa && arready) begin
				pa = 1'b0;
				arvalid <= 1'b0;
			end
			if (pr && rvalid) begin
				pr = 1'b0;
				rready <= 1'b0;
			end
		end
	endtask
endmodule

// *** verif/tb_fp_compare_classify_flags.sv ***
// Self-checking bench for the compare, classify and flag unit.
`timescale 1ns/10ps
module tb_fp_compare_classify_flags;
	logic clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int miscompares = 0, compares = 0, cyc = 0, seed = 32'hce83, r;
	logic [15:0] cc = '0, fl = '0, pc = '0;
	logic inv = 1'b0;
	logic [15:0] cc_map[4] = '{16'h0000, 16'h0100, 16'h4000, 16'h4500};
	logic [15:0] fl_map[4] = '{16'h0000, 16'h0001, 16'h0040, 16'h0045};
	logic [15:0] th[5] = '{16'h4000, 16'hC000, 16'h0000, 16'h3FFF, 16'h7FFF};
	logic [31:0] tm[5] = '{32'h8000_0000, 32'h8000_0000, 32'h0, 32'h8000_0000, 32'hC000_0000};
	logic [15:0] sh[5] = '{16'h3FFF, 16'hBFFF, 16'h8000, 16'h8000, 16'h3FFF};
	logic [31:0] sm[5] = '{32'h8000_0000, 32'h8000_0000, 32'h0, 32'h0, 32'h8000_0000};
	int kd[5] = '{0, 1, 2, 0, 3};
	logic [15:0] xh[6] = '{16'hFFFF, 16'h3FFF, 16'h0000, 16'h8000, 16'h7FFF, 16'h3FFF};
	logic [31:0] xm[6] = '{32'h8000_0000, 32'h8000_0000, 32'h1, 32'h0, 32'hC000_0000, 32'h0};
	logic [15:0] xc[6] = '{16'h0700, 16'h0400, 16'h4400, 16'h4200, 16'h0100, 16'h0000};
	logic [3:0] pop_op[5] = '{4'h2, 4'h3, 4'h8, 4'hB, 4'hD};
	int pop_n[5] = '{1, 2, 1, 1, 1};
	fp_compare_classify_flags dut (.clk(clk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	axi_lite_master m (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic end_sim();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk_rd(input logic [33:0] e, input logic [33:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] read exp %h got %h", e, g);
		end
	endtask
	task automatic chk_wr(input logic [1:0] e, input logic [1:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] bresp exp %h got %h", e, g);
		end
	endtask
	// Results are compared at the edge that completes each answer, oldest note first.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rvalid && rready) chk_rd(rq.pop_front(), {rresp, rdata});
		if (bvalid && bready) chk_wr(bq.pop_front(), bresp);
		if (cyc == 40000) begin
			miscompares++;
			end_sim();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
		bq.push_back(e);
		m.wr(a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
		rq.push_back({e, d});
		m.rd(a);
	endtask
	task automatic ld(input logic [15:0] h, input logic [31:0] mm, input logic [15:0] s, input logic [31:0] sl);
		logic [31:0] v[6];
		v = '{32'h0, mm, {16'h0, h}, 32'h0, sl, {16'h0, s}};
		for (int i = 0; i < 6; i++) wr(8'(4 * i), v[i]);
	endtask
	task automatic cmd(input logic [3:0] op, input int pops = 0);
		wr(8'h1C, {28'h0, op});
		pc += 16'(pops);
	endtask
	function automatic logic [31:0] swv();
		return {16'h0, cc | {2'h0, pc[2:0], 11'h0} | {15'h0, inv}};
	endfunction
	initial begin
		rst_b = 1'b0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		rd(8'h20, 32'h0);
		rd(8'h2C, 32'h1);
		rd(8'h40, 32'h0, 2'h2);
		wr(8'h2C, 32'h0, 2'h2);
		foreach (th[i]) begin
			ld(th[i], tm[i], sh[i], sm[i]);
			cmd(4'h1);
			cc = cc_map[kd[i]];
			inv = inv | (kd[i] == 3);
			rd(8'h20, swv());
			cmd(4'hF);
			rd(8'h28, swv());
			rd(8'h24, {16'h0, fl});
			cmd(4'hA);
			fl = fl_map[kd[i]];
			rd(8'h24, {16'h0, fl});
			rd(8'h20, swv());
		end
		wr(8'h20, 32'h1);
		inv = 1'b0;
		cmd(4'hC);
		rd(8'h20, swv());
		ld(16'hBFFF, 32'h8000_0000, 16'hC000, 32'h8000_0000);
		cmd(4'h9);
		cc = cc_map[1];
		rd(8'h20, swv());
		ld(16'h3FFF, 32'h8000_0000, 16'h0, 32'h0);
		for (int i = 0; i < 7; i++) begin
			r = (i < 4) ? i - 1 : $random(seed);
			wr(8'h18, 32'(r));
			cmd(4'h7);
			cc = (r > 1) ? cc_map[1] : (r == 1) ? cc_map[2] : cc_map[0];
			rd(8'h20, swv());
		end
		ld(16'h3FFF, 32'h8000_0000, 16'h3FFF, 32'h8000_0000);
		wr(8'h18, 32'h1);
		cc = cc_map[2];
		foreach (pop_op[i]) begin
			wr(8'h08, 32'h3FFF);
			cmd(pop_op[i], pop_n[i]);
			rd(8'h20, swv());
			rd(8'h30, {16'h0, pc});
		end
		rd(8'h24, 32'h40);
		cmd(4'hE);
		cc = 16'h4100;
		rd(8'h20, swv());
		foreach (xh[i]) begin
			ld(xh[i], xm[i], 16'h0, 32'h0);
			cmd(4'hE);
			cc = xc[i];
			rd(8'h20, swv());
		end
		cmd(4'hF);
		rd(8'h28, swv());
		repeat (5) @(posedge clk);
		end_sim();
	end
endmodule
